// ===== core/ddc_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed in clocks
`timescale 1ns/1ps
module ddc_bus_cycle
#(
    parameter int WE_CYCLES = ddc_pkg::WE_CYC,
    parameter int ACC_CYCLES = ddc_pkg::ACC_CYC,
    parameter int HOLD_CYCLES = ddc_pkg::HOLD_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic is_write,
    input wire logic [26:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_sync,
    output logic done,
    output logic [15:0] rdata_q,
    output logic [26:0] addr_q,
    output logic [15:0] dq_out_q,
    output logic dq_oe_q,
    output logic ce_n_q,
    output logic oe_n_q,
    output logic we_n_q
);
    import ddc_pkg::*;

    typedef enum logic [2:0]
    {
        BC_IDLE = 3'b001,
        BC_STROBE = 3'b010,
        BC_HOLD = 3'b100
    } bc_state_type;

    bc_state_type state_q;
    logic [7:0] cnt_q;
    logic wr_q;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= BC_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                BC_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= BC_STROBE;
                        wr_q <= is_write;
                        cnt_q <= is_write ? 8'(WE_CYCLES) : 8'(ACC_CYCLES);
                    end
                end
                BC_STROBE:
                begin
                    if (cnt_q == 8'h01)
                    begin
                        state_q <= BC_HOLD;
                        cnt_q <= 8'(HOLD_CYCLES);
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                BC_HOLD:
                begin
                    if (cnt_q == 8'h01)
                        state_q <= BC_IDLE;
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
            endcase
        end
    end

    assign done = (state_q == BC_HOLD) && (cnt_q == 8'h01);

    // Pin drive: CE# high between cycles so every read starts a new access
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            addr_q <= 27'h0000000;
            dq_out_q <= 16'h0000;
            dq_oe_q <= 1'b0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
        end
        else if (state_q == BC_IDLE && start)
        begin
            addr_q <= addr;
            dq_out_q <= wdata;
            dq_oe_q <= is_write;
            ce_n_q <= 1'b0;
            oe_n_q <= is_write;
            we_n_q <= ~is_write;
        end
        else if (state_q == BC_STROBE && cnt_q == 8'h01)
        begin
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
        end
        else if (done)
            dq_oe_q <= 1'b0;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_q <= 16'h0000;
        else if (state_q == BC_STROBE && cnt_q == 8'h01 && !wr_q)
            rdata_q <= dq_sync;
    end

endmodule : ddc_bus_cycle

// ===== core/ddc_host.sv
// Host controller issuing die-steered commands to a two-die NOR flash
// Overview of operation
// - Every write reaches both dies; die select bit picks the accepting die.
// - Host adds die base, zero or 4000000h, to every command address.
// - Unlock cycles write AA at 555 then 55 at 2AA, die base added.
// - Sector erase: AA,55,80,AA,55 then 30 at sector address.
// - Command address arguments are steered to the die by its select bit.
// - Die select bit applied on command writes and on identification reads; plain reads use address bit 26.
// - Protect status valid only for sector given at identification entry.
`timescale 1ns/1ps
module ddc_host
(
    input wire logic clk,
    input wire logic reset,
    input wire ddc_pkg::ddc_req_type req,
    input wire logic req_valid,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data_q,
    output ddc_pkg::ddc_id_type id_q,
    output logic busy,
    output ddc_pkg::ddc_pins_type pins,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_n
);
    import ddc_pkg::*;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_CYCLE = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_DONE = 5'b01000,
        ST_POLL = 5'b10000
    } host_state_type;

    host_state_type state_q;
    ddc_req_type cur_q;
    logic [3:0] step_q;
    logic [26:0] base_q;
    logic [15:0] dq_s1_q;
    logic [15:0] dq_s2_q;
    logic rb_s1_q;
    logic rb_s2_q;
    logic [2:0] poll_q;
    logic cyc_start;
    logic cyc_write;
    logic cyc_done;
    logic [26:0] cyc_addr;
    logic [15:0] cyc_data;
    logic [15:0] cyc_rdata;
    logic [3:0] last_step;

    // Die base: select bit alone carries the die choice
    function automatic logic [26:0] die_addr(input logic [26:0] base,
                                             input logic [26:0] ofs);
        die_addr = base | {1'b0, ofs[25:0]};
    endfunction : die_addr

    ////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end
        else
        begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
        end
    end

    assign busy = ~rb_s2_q;

    ////////////////////////////////////////////////////////////////////
    // Step sequencer per operation
    always_comb
    begin
        unique case (cur_q.op)
            DDC_OP_ERASE: last_step = 4'h5;
            DDC_OP_ID: last_step = 4'h9;
            default: last_step = 4'h0;
        endcase
    end

    always_comb
    begin
        cyc_write = 1'b1;
        cyc_addr = die_addr(base_q, UNLOCK1_OFS);
        cyc_data = UNLOCK1_DAT;
        unique case (cur_q.op)
            DDC_OP_READ:
            begin
                cyc_write = 1'b0;
                cyc_addr = cur_q.addr;
            end
            DDC_OP_WRITE:
            begin
                cyc_addr = die_addr(base_q, cur_q.addr);
                cyc_data = cur_q.data;
            end
            DDC_OP_ERASE:
            begin
                unique case (step_q)
                    4'h0, 4'h3: cyc_data = UNLOCK1_DAT;
                    4'h1, 4'h4:
                    begin
                        cyc_addr = die_addr(base_q, UNLOCK2_OFS);
                        cyc_data = UNLOCK2_DAT;
                    end
                    4'h2: cyc_data = ERASE_SETUP_DAT;
                    default:
                    begin
                        cyc_addr = die_addr(base_q, cur_q.addr);
                        cyc_data = SECTOR_ERASE_DAT;
                    end
                endcase
            end
            default:
            begin
                // Enter ID with sector address, read six words, exit
                unique case (step_q)
                    4'h0: cyc_data = UNLOCK1_DAT;
                    4'h1:
                    begin
                        cyc_addr = die_addr(base_q, UNLOCK2_OFS);
                        cyc_data = UNLOCK2_DAT;
                    end
                    4'h2:
                    begin
                        cyc_addr = die_addr(base_q, cur_q.addr);
                        cyc_data = ID_ENTER_DAT;
                    end
                    4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
                    begin
                        cyc_write = 1'b0;
                        cyc_addr = die_addr(base_q, id_ofs(step_q));
                    end
                    default:
                    begin
                        cyc_addr = base_q;
                        cyc_data = ID_EXIT_DAT;
                    end
                endcase
            end
        endcase
    end

    function automatic logic [26:0] id_ofs(input logic [3:0] s);
        unique case (s)
            4'h3: id_ofs = ID_MFR_OFS;
            4'h4: id_ofs = ID_DEV1_OFS;
            4'h5: id_ofs = ID_DEV2_OFS;
            4'h6: id_ofs = ID_DEV3_OFS;
            4'h7: id_ofs = ID_SECURE_OFS;
            default: id_ofs = {1'b0, cur_q.addr[25:0]} + ID_PROT_OFS;
        endcase
    endfunction : id_ofs

    assign cyc_start = (state_q == ST_CYCLE);
    assign req_ready = (state_q == ST_IDLE) && rb_s2_q;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            cur_q <= '0;
            step_q <= 4'h0;
            base_q <= DIE0_BASE;
            poll_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (req_valid && req_ready)
                    begin
                        cur_q <= req;
                        step_q <= 4'h0;
                        base_q <= req.die ? DIE1_BASE : DIE0_BASE;
                        state_q <= ST_CYCLE;
                    end
                end
                ST_CYCLE:
                    state_q <= ST_WAIT;
                ST_WAIT:
                begin
                    if (cyc_done)
                    begin
                        if (step_q == last_step)
                            state_q <= ST_DONE;
                        else
                        begin
                            step_q <= step_q + 4'h1;
                            state_q <= ST_CYCLE;
                        end
                    end
                end
                ST_DONE:
                begin
                    poll_q <= 3'h4;
                    state_q <= ST_POLL;
                end
                ST_POLL:
                begin
                    // Allow the busy pin time to fall before trusting it
                    if (poll_q != 3'h0)
                        poll_q <= poll_q - 3'h1;
                    else if (rb_s2_q)
                        state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign rsp_valid = (state_q == ST_DONE);

    ////////////////////////////////////////////////////////////////////
    // Response capture and identification decode
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_data_q <= 16'h0000;
            id_q <= '0;
        end
        else if (state_q == ST_WAIT && cyc_done && !cyc_write)
        begin
            rsp_data_q <= cyc_rdata;
            if (cur_q.op == DDC_OP_ID)
            begin
                unique case (step_q)
                    4'h3: id_q.mfr <= cyc_rdata;
                    4'h4: id_q.dev1 <= cyc_rdata;
                    4'h5: id_q.dev2 <= cyc_rdata;
                    4'h6: id_q.dev3 <= cyc_rdata;
                    4'h7:
                    begin
                        id_q.secure <= cyc_rdata;
                        id_q.high_sector_variant <=
                            (cyc_rdata[7:0] == SEC_HI_OPEN) ||
                            (cyc_rdata[7:0] == SEC_HI_LOCK);
                        id_q.factory_locked <=
                            (cyc_rdata[7:0] == SEC_HI_LOCK) ||
                            (cyc_rdata[7:0] == SEC_LO_LOCK);
                    end
                    default:
                    begin
                        id_q.prot <= cyc_rdata;
                        id_q.sector_locked <=
                            (cyc_rdata[7:0] == PROT_LOCKED);
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address pins are held between cycles so the device may sleep
    ddc_bus_cycle u_cycle
    (
        .clk(clk),
        .reset(reset),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .dq_sync(dq_s2_q),
        .done(cyc_done),
        .rdata_q(cyc_rdata),
        .addr_q(pins.addr),
        .dq_out_q(pins.dq_out),
        .dq_oe_q(pins.dq_oe),
        .ce_n_q(pins.ce_n),
        .oe_n_q(pins.oe_n),
        .we_n_q(pins.we_n)
    );

    assign pins.reset_n = ~reset;

endmodule : ddc_host

// ===== core/ddc_pkg.sv
// Package: constants and carrier types for the dual die command host
package ddc_pkg;

    localparam int ADDR_W = 27;
    localparam int DATA_W = 16;
    localparam int DIE_BIT = 26;
    localparam logic [26:0] DIE0_BASE = 27'h0000000;
    localparam logic [26:0] DIE1_BASE = 27'h4000000;
    localparam logic [26:0] UNLOCK1_OFS = 27'h0000555;
    localparam logic [26:0] UNLOCK2_OFS = 27'h00002AA;
    localparam logic [15:0] UNLOCK1_DAT = 16'h00AA;
    localparam logic [15:0] UNLOCK2_DAT = 16'h0055;
    localparam logic [15:0] ERASE_SETUP_DAT = 16'h0080;
    localparam logic [15:0] SECTOR_ERASE_DAT = 16'h0030;
    localparam logic [15:0] ID_ENTER_DAT = 16'h0090;
    localparam logic [15:0] ID_EXIT_DAT = 16'h00F0;
    localparam logic [26:0] ID_MFR_OFS = 27'h0000000;
    localparam logic [26:0] ID_DEV1_OFS = 27'h0000001;
    localparam logic [26:0] ID_PROT_OFS = 27'h0000002;
    localparam logic [26:0] ID_SECURE_OFS = 27'h0000003;
    localparam logic [26:0] ID_DEV2_OFS = 27'h000000E;
    localparam logic [26:0] ID_DEV3_OFS = 27'h000000F;
    localparam logic [7:0] SEC_HI_OPEN = 8'h3F;
    localparam logic [7:0] SEC_HI_LOCK = 8'hBF;
    localparam logic [7:0] SEC_LO_OPEN = 8'h2F;
    localparam logic [7:0] SEC_LO_LOCK = 8'hAF;
    localparam logic [7:0] PROT_LOCKED = 8'h01;
    localparam logic [7:0] PROT_OPEN = 8'h00;

    // Bus timing, ns, and cycle counts at 200 MHz
    localparam int CLK_PS = 5000;
    localparam int T_WE_NS = 35;
    localparam int T_ACC_NS = 110;
    localparam int T_HOLD_NS = 20;
    localparam int WE_CYC = (T_WE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;

    typedef enum logic [2:0]
    {
        DDC_OP_READ = 3'h0,
        DDC_OP_WRITE = 3'h1,
        DDC_OP_ERASE = 3'h2,
        DDC_OP_ID = 3'h3
    } ddc_op_type;

    typedef struct packed
    {
        ddc_op_type op;
        logic die;
        logic [26:0] addr;
        logic [15:0] data;
    } ddc_req_type;

    typedef struct packed
    {
        logic [15:0] mfr;
        logic [15:0] dev1;
        logic [15:0] dev2;
        logic [15:0] dev3;
        logic [15:0] secure;
        logic [15:0] prot;
        logic factory_locked;
        logic sector_locked;
        logic high_sector_variant;
    } ddc_id_type;

    typedef struct packed
    {
        logic [26:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } ddc_pins_type;

endpackage : ddc_pkg

// ===== test/ddc_flash_model.sv
// Behavioural two-die flash that answers the host's bus cycles
`timescale 1ns/1ps
module ddc_flash_model
#(
    parameter logic [15:0] MFR_ID = 16'h00A5, // Arbitrary value
    parameter logic [15:0] DEV1_ID = 16'h1111, // Arbitrary value
    parameter logic [15:0] DEV2_ID = 16'h2222, // Arbitrary value
    parameter logic [15:0] DEV3_ID = 16'h3333, // Arbitrary value
    parameter int BUSY_CYC = 40
)
(
    input wire logic clk,
    input wire ddc_pkg::ddc_pins_type pins,
    input wire logic high_var,
    input wire logic fact_lock,
    input wire logic [26:0] locked_sa,
    output logic [15:0] dq_in,
    output logic ready_busy_n
);
    import ddc_pkg::*;
    localparam logic [25:0] SEQ_OFS [0:4] = '{26'h555, 26'h2AA, 26'h555,
        26'h555, 26'h2AA};
    localparam logic [7:0] SEQ_DAT [0:4] = '{8'hAA, 8'h55, 8'h80, 8'hAA,
        8'h55};
    logic [26:0] log_addr [0:7];
    logic [15:0] log_dat [0:7];
    int log_n = 0;
    int step [0:1] = '{0, 0};
    logic id_mode [0:1] = '{1'b0, 1'b0};
    logic [26:0] id_sa [0:1];
    int erase_cnt [0:1] = '{0, 0};
    int busy_cnt = 0;
    int stable_cnt = 0;
    logic asleep = 1'b0;
    logic we_prev = 1'b1;
    logic [26:0] addr_prev = '0;
    logic [15:0] dq_last = 16'h0000;
    logic [15:0] word;
    logic d;
    logic d_r;
    logic [25:0] o;
    logic [7:0] v;

    ////////////////////////////////////////////////////////////////////////
    // Command decode, one sequence state per die
    always @(posedge clk)
    begin
        if (busy_cnt > 0)
            busy_cnt = busy_cnt - 1;
        stable_cnt = (pins.addr == addr_prev) ? stable_cnt + 1 : 0;
        addr_prev = pins.addr;
        asleep = stable_cnt > 50;
        if (!pins.ce_n && !pins.oe_n)
            dq_last = word;
        if (!pins.reset_n)
        begin
            step = '{0, 0};
            id_mode = '{1'b0, 1'b0};
        end
        else if (!pins.we_n && we_prev && !pins.ce_n)
        begin
            d = pins.addr[26];
            o = pins.addr[25:0];
            v = pins.dq_out[7:0];
            log_addr[log_n % 8] = pins.addr;
            log_dat[log_n % 8] = pins.dq_out;
            log_n++;
            if (v == 8'hF0)
                id_mode[d] = 1'b0;
            else if (step[d] == 2 && v == 8'h90)
            begin
                id_mode[d] = 1'b1;
                id_sa[d] = pins.addr;
            end
            if (step[d] == 5 && v == 8'h30)
            begin
                erase_cnt[d]++;
                busy_cnt = BUSY_CYC;
            end
            step[d] = (step[d] < 5 && o == SEQ_OFS[step[d]]
                && v == SEQ_DAT[step[d]]) ? step[d] + 1 : 0;
        end
        we_prev = pins.we_n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and ready/busy
    always_comb
    begin
        d_r = pins.addr[26];
        word = pins.addr[15:0] ^ {5'h00, pins.addr[26:16]};
        if (id_mode[d_r])
        begin
            case (pins.addr[3:0])
            4'h0: word = MFR_ID;
            4'h1: word = DEV1_ID;
            4'hE: word = DEV2_ID;
            4'hF: word = DEV3_ID;
            4'h3: word = {8'hFF, fact_lock, 2'b01, high_var, 4'hF};
            4'h2: word = (pins.addr[25:16] != id_sa[d_r][25:16]) ? 16'h5A5A
                : {15'h0000, pins.addr[26:16] == locked_sa[26:16]};
            default: word = 16'hFFFF;
            endcase
        end
    end
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? word : ~dq_last;
    assign ready_busy_n = busy_cnt == 0;
endmodule : ddc_flash_model

// ===== test/ddc_host_monitor.sv
// Checker for die steering and command word offsets on the host pins
`timescale 1ns/1ps
module ddc_host_monitor
(
    input wire logic clk,
    input wire logic reset,
    input wire ddc_pkg::ddc_req_type req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic busy,
    input wire ddc_pkg::ddc_pins_type pins
);
    import ddc_pkg::*;
    ddc_req_type cur_q;
    logic cmd_op;

    ////////////////////////////////////////////////////////////////////////
    // Request in flight
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cur_q <= '0;
        else if (req_valid && req_ready)
            cur_q <= req;
    end
    assign cmd_op = cur_q.op == DDC_OP_ERASE || cur_q.op == DDC_OP_ID;

    ////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence take_s;
        req_valid && req_ready;
    endsequence
    sequence strobe_s;
        $fell(pins.we_n);
    endsequence
    sequence cmd_wr_s(d);
        strobe_s ##0 (cmd_op && pins.dq_out[7:0] == d);
    endsequence

    die_steer_a: assert property (strobe_s |-> pins.addr[26] == cur_q.die)
        else $error("Write strobe reached the wrong die");
    unlock_first_a: assert property (cmd_wr_s(8'hAA)
        |-> pins.addr[25:0] == UNLOCK1_OFS[25:0])
        else $error("First unlock word at a wrong offset");
    unlock_second_a: assert property (cmd_wr_s(8'h55)
        |-> pins.addr[25:0] == UNLOCK2_OFS[25:0])
        else $error("Second unlock word at a wrong offset");
    erase_setup_a: assert property (cmd_wr_s(8'h80)
        |-> pins.addr[25:0] == UNLOCK1_OFS[25:0])
        else $error("Erase setup word at a wrong offset");
    erase_target_a: assert property (cmd_wr_s(8'h30)
        |-> pins.addr == {cur_q.die, cur_q.addr[25:0]})
        else $error("Erase confirm not at the based sector address");
    id_sector_a: assert property (cmd_wr_s(8'h90)
        |-> pins.addr[25:0] == cur_q.addr[25:0])
        else $error("Identification entry not at the sector address");
    resp_die_a: assert property (cur_q.op == DDC_OP_ID ##0 $fell(pins.oe_n)
        |-> pins.addr[26] == cur_q.die)
        else $error("Identification read from the wrong die");
    busy_refuse_a: assert property (busy |-> !req_ready)
        else $error("Request accepted while the flash is busy");
    poll_guard_a: assert property (rsp_valid |-> !req_ready [*4])
        else $error("Request accepted inside the poll guard");
    strobe_frame_a: assert property (!pins.we_n
        |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
        else $error("Write strobe without select or data drive");
    op_done_a: assert property (take_s |-> ##[1:400] rsp_valid)
        else $error("Operation did not complete");
endmodule : ddc_host_monitor

bind ddc_host ddc_host_monitor ddc_host_monitor_i
(
    .clk(clk),
    .reset(reset),
    .req(req),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .busy(busy),
    .pins(pins)
);

// ===== test/test_dual_die_command_addressing.sv
// Self-checking bench for the dual die command host
`timescale 1ns/1ps
module test_dual_die_command_addressing;
    import ddc_pkg::*;
    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
    localparam logic [15:0] DEV1 = 16'h1111; // Arbitrary value
    localparam logic [15:0] DEV2 = 16'h2222; // Arbitrary value
    localparam logic [15:0] DEV3 = 16'h3333; // Arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    ddc_req_type req = '0;
    logic req_valid = 1'b0;
    logic req_ready, rsp_valid, busy, ready_busy_n;
    logic [15:0] rsp_data_q, dq_in;
    ddc_id_type id_q;
    ddc_pins_type pins;
    logic high_var = 1'b0;
    logic fact_lock = 1'b0;
    logic [26:0] locked_sa = '0;
    int miscompares = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    ddc_host ddc_host_i (.clk(clk), .reset(reset), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data_q(rsp_data_q), .id_q(id_q), .busy(busy), .pins(pins),
        .dq_in(dq_in), .ready_busy_n(ready_busy_n));
    ddc_flash_model #(.MFR_ID(MFR), .DEV1_ID(DEV1), .DEV2_ID(DEV2),
        .DEV3_ID(DEV3)) ddc_flash_model_i (.clk(clk), .pins(pins),
        .high_var(high_var), .fact_lock(fact_lock), .locked_sa(locked_sa),
        .dq_in(dq_in), .ready_busy_n(ready_busy_n));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got,
                exp);
        end
    endtask : check

    task automatic give_up(input string what);
        miscompares++;
        $display("mismatch at %0t: timeout on %s", $time, what);
        final_report();
    endtask : give_up

    task automatic run_op(input ddc_op_type op, input logic die,
        input logic [26:0] addr, input logic [15:0] data);
        int n;
        req = '{op: op, die: die, addr: addr, data: data};
        req_valid = 1'b1;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++)
            @(negedge clk);
        if (req_ready !== 1'b1)
            give_up("request");
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 500 && rsp_valid !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        if (rsp_valid !== 1'b1)
            give_up("response");
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic read_scn;
        run_op(DDC_OP_READ, 1'b0, 27'h0001234, 16'h0000);
        check(rsp_data_q, 16'h1234, "lower die read");
        run_op(DDC_OP_READ, 1'b0, 27'h4001234, 16'h0000);
        check(rsp_data_q, 16'h1634, "upper die read");
        @(negedge clk);
    endtask : read_scn

    task automatic write_scn;
        int n0;
        n0 = ddc_flash_model_i.log_n;
        run_op(DDC_OP_WRITE, 1'b1, 27'h0000100, 16'h1234);
        run_op(DDC_OP_WRITE, 1'b0, 27'h4000100, 16'h0055);
        check(ddc_flash_model_i.log_addr[n0 % 8], 27'h4000100, "upper");
        check(ddc_flash_model_i.log_dat[n0 % 8], 16'h1234, "data");
        check(ddc_flash_model_i.log_addr[(n0 + 1) % 8], 27'h100, "lower");
        @(negedge clk);
    endtask : write_scn

    task automatic erase_scn(input logic die);
        logic [26:0] base;
        logic [26:0] ofs [0:5];
        logic [15:0] dat [0:5];
        int n0;
        int e0;
        int e1;
        int n;
        base = die ? DIE1_BASE : DIE0_BASE;
        ofs = '{UNLOCK1_OFS, UNLOCK2_OFS, UNLOCK1_OFS, UNLOCK1_OFS,
            UNLOCK2_OFS, 27'h0020000};
        dat = '{UNLOCK1_DAT, UNLOCK2_DAT, ERASE_SETUP_DAT, UNLOCK1_DAT,
            UNLOCK2_DAT, SECTOR_ERASE_DAT};
        n0 = ddc_flash_model_i.log_n;
        e0 = ddc_flash_model_i.erase_cnt[0];
        e1 = ddc_flash_model_i.erase_cnt[1];
        run_op(DDC_OP_ERASE, die, 27'h0020000, 16'h0000);
        check(busy, 1'b1, "busy after erase");
        check(req_ready, 1'b0, "refused while busy");
        for (int i = 0; i < 6; i++)
        begin
            check(ddc_flash_model_i.log_addr[(n0 + i) % 8], base | ofs[i], "adr");
            check(ddc_flash_model_i.log_dat[(n0 + i) % 8], dat[i], "dat");
        end
        check(ddc_flash_model_i.erase_cnt[0], e0 + !die, "lower die");
        check(ddc_flash_model_i.erase_cnt[1], e1 + die, "upper die");
        for (n = 0; n < 200 && busy !== 1'b0; n++)
            @(negedge clk);
        if (busy !== 1'b0)
            give_up("ready");
    endtask : erase_scn

    task automatic id_scn(input logic die, input logic hv, input logic fl,
        input logic sl);
        high_var = hv;
        fact_lock = fl;
        locked_sa = {die, sl ? 26'h0030000 : 26'h0050000};
        run_op(DDC_OP_ID, die, 27'h0030000, 16'h0000);
        check(id_q.mfr, MFR, "maker code");
        check({id_q.dev1, id_q.dev2}, {DEV1, DEV2}, "device words");
        check(id_q.dev3, DEV3, "third device word");
        check(id_q.secure[7:0], hv ? (fl ? SEC_HI_LOCK : SEC_HI_OPEN)
            : (fl ? SEC_LO_LOCK : SEC_LO_OPEN), "secure word");
        check({id_q.factory_locked, id_q.high_sector_variant}, {fl, hv}, "var");
        check(id_q.prot[7:0], sl ? PROT_LOCKED : PROT_OPEN, "protect");
        check(id_q.sector_locked, sl, "protect flag");
        check(ddc_flash_model_i.id_mode[die], 1'b0, "mode left");
        @(negedge clk);
    endtask : id_scn

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (2) @(negedge clk);
        check({pins.ce_n, pins.we_n, pins.oe_n}, 3'b111, "idle strobes");
        check({pins.dq_oe, pins.reset_n}, 2'b00, "reset pins");
        repeat (2) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        read_scn();
        write_scn();
        erase_scn(1'b0);
        erase_scn(1'b1);
        id_scn(1'b0, 1'b1, 1'b0, 1'b1);
        id_scn(1'b1, 1'b1, 1'b1, 1'b0);
        id_scn(1'b0, 1'b0, 1'b1, 1'b1);
        id_scn(1'b1, 1'b0, 1'b0, 1'b0);
        final_report();
    end
endmodule : test_dual_die_command_addressing
